// ==== hdl/asc_sequencer.sv ====
/*
 * A/D enable and sample/convert sequencer with APB registers and result buffer.
 * Assumes conv_data holds the result by the twelfth conversion clock tick and
 * rc_tick and ext_trigger are one-cycle pulses synchronous to pclk.
 */
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"

// Behaviour
// - Enable bit powers the converter; zero shuts digital and analog parts off.
// - Control register contents are kept while the converter is disabled, except the sample bit, which clears.
// - Disable and re-enable leave result buffer words untouched.
// - Without auto-sample, setting the sample bit starts sampling.
// - Software trigger: clearing the sample bit ends sampling, starts conversion.
// - Manual mode: no new sampling until software sets the sample bit.
// - Auto-sample: new sampling begins whenever a conversion completes.
// - Auto-sample: next sampling phase uses the next channel.
// - Sample bit reads sampling state; conversion start clears done; completion sets done, reset clears it.
// - Clearing auto-sample finishes current sequence, then stops restarting.
// - Selected trigger ends sampling; four-bit field selects the trigger.
// - Auto-sample with software trigger: completion sets the sample bit again.
// - Clocked trigger: count programmed conversion clocks from sampling start.
// - Clocked trigger with auto-sample runs sequences back to back.
// - Every conversion completes on the twelfth conversion clock tick after its start.
// - Sequencing runs on the conversion clock, RC or divided clock.
// - Divided clock period is two oscillator periods times divider plus one.
// - RC select uses the RC clock and ignores the divider.
module asc_sequencer
    import asc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rc_tick,
    input  wire logic        ext_trigger,
    input  wire logic [11:0] conv_data,
    output logic             analog_power,
    output logic             sh_sample,
    output logic             conv_active,
    output logic [3:0]       channel_sel
);

    // ****************************************************************
    // Decoding helpers and state
    // ****************************************************************

    // Word offset hit within the 12-bit address window
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        addr_hit = (a[11:2] == off[11:2]);
    endfunction

    function automatic logic is_buf(input logic [11:0] a);
        is_buf = (a[11:2] >= `ASC_OFF_BUF_BASE >> 2) && (a[11:2] <= `ASC_OFF_BUF_LAST >> 2);
    endfunction

    asc_state_t  state_q;
    logic        enable_q;
    logic        auto_q;
    logic [3:0]  trig_q;
    logic [7:0]  div_q;
    logic [4:0]  sample_time_count_q;
    logic        rc_sel_q;
    logic        sample_q;
    logic        done_q;
    logic [4:0]  sample_control_cnt_q;
    logic [3:0]  conv_cnt_q;
    asc_ptr_t    wr_ptr_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        conv_active_q;

    logic        tad_tick;
    logic        wr_en, rd_setup, mapped, sw_low_wr;
    logic        start_conv, conv_done;
    logic [11:0] buf_rd;

    // ****************************************************************
    // APB access decode
    // ****************************************************************

    // Write takes effect only at the access edge where pready is high
    assign wr_en     = psel && penable && pready_q && pwrite;
    assign rd_setup  = psel && !penable;
    assign mapped    = addr_hit(paddr, `ASC_OFF_CTRL_LOW) || addr_hit(paddr, `ASC_OFF_CTRL_HIGH)
                    || addr_hit(paddr, `ASC_OFF_CTRL_THREE) || addr_hit(paddr, `ASC_OFF_STATUS)
                    || is_buf(paddr);
    assign sw_low_wr = wr_en && addr_hit(paddr, `ASC_OFF_CTRL_LOW) && enable_q;

    // No wait state: answer prepared during setup, presented in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= rd_setup;
            pslverr_q <= rd_setup && !mapped;
        end
    end

    // Read data mux, sampled in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (rd_setup)
        begin
            prdata_q <= 32'h0000_0000;
            if (addr_hit(paddr, `ASC_OFF_CTRL_LOW))
            begin
                prdata_q[`ASC_LOW_TRIG_LSB +: 4]  <= trig_q;
                prdata_q[`ASC_LOW_AUTO_BIT]       <= auto_q;
                prdata_q[`ASC_LOW_SAMPLE_BIT]     <= sample_q;
                prdata_q[`ASC_LOW_DONE_BIT]       <= done_q;
            end
            else if (addr_hit(paddr, `ASC_OFF_CTRL_HIGH))
                prdata_q[`ASC_HIGH_ENABLE_BIT] <= enable_q;
            else if (addr_hit(paddr, `ASC_OFF_CTRL_THREE))
            begin
                prdata_q[`ASC_THREE_DIV_LSB +: 8]  <= div_q;
                prdata_q[`ASC_THREE_SAMPLE_TIME_COUNT_LSB +: 5] <= sample_time_count_q;
                prdata_q[`ASC_THREE_RC_BIT]        <= rc_sel_q;
            end
            else if (addr_hit(paddr, `ASC_OFF_STATUS))
                prdata_q[7:0] <= {wr_ptr_q, conv_cnt_q};
            else if (is_buf(paddr))
                prdata_q[11:0] <= buf_rd;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************

    // Control fields; dropping enable leaves every other field but the sample bit as it is.
    // The trigger field is not locked while enabled: software keeps off it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q <= 1'b0;
            trig_q   <= `ASC_TRIG_SOFTWARE;
            auto_q   <= 1'b0;
            div_q    <= `ASC_RST_DIVIDER;
            sample_time_count_q   <= `ASC_RST_SAMPLE_TIME_COUNT;
            rc_sel_q <= 1'b0;
        end
        else if (wr_en && addr_hit(paddr, `ASC_OFF_CTRL_HIGH))
            enable_q <= pwdata[`ASC_HIGH_ENABLE_BIT];
        else if (wr_en && addr_hit(paddr, `ASC_OFF_CTRL_LOW))
        begin
            trig_q <= pwdata[`ASC_LOW_TRIG_LSB +: 4];
            auto_q <= pwdata[`ASC_LOW_AUTO_BIT];
        end
        else if (wr_en && addr_hit(paddr, `ASC_OFF_CTRL_THREE))
        begin
            div_q    <= pwdata[`ASC_THREE_DIV_LSB +: 8];
            sample_time_count_q   <= pwdata[`ASC_THREE_SAMPLE_TIME_COUNT_LSB +: 5];
            rc_sel_q <= pwdata[`ASC_THREE_RC_BIT];
        end
    end

    // ****************************************************************
    // Conversion clock and sampling end
    // ****************************************************************
    asc_tad_div u_tad (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (enable_q),
        .rc_select (rc_sel_q),
        .rc_tick   (rc_tick),
        .divider   (div_q),
        .tad_tick  (tad_tick)
    );

    // Sampling ends on a written zero, a tick count or an external pulse
    always_comb
    begin
        start_conv = 1'b0;
        if (state_q == ASC_ST_SAMPLE)
        begin
            if (trig_q == `ASC_TRIG_SOFTWARE)
                start_conv = sw_low_wr && !pwdata[`ASC_LOW_SAMPLE_BIT];
            else if (trig_q == `ASC_TRIG_CLOCKED)
                start_conv = tad_tick && (sample_control_cnt_q + 5'h01 >= sample_time_count_q);
            else
                start_conv = ext_trigger;
        end
    end

    assign conv_done = (state_q == ASC_ST_CONVERT) && tad_tick
                    && (conv_cnt_q == `ASC_CONV_TAD - 4'h1);

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // Phase machine; disable returns to idle immediately.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= ASC_ST_IDLE;
        else if (!enable_q)
            state_q <= ASC_ST_IDLE;
        else
        begin
            unique case (state_q)
                ASC_ST_IDLE:
                    if (sw_low_wr && pwdata[`ASC_LOW_SAMPLE_BIT])
                        state_q <= ASC_ST_SAMPLE;
                ASC_ST_SAMPLE:
                    if (start_conv)
                        state_q <= ASC_ST_CONVERT;
                    else if (sw_low_wr && !pwdata[`ASC_LOW_SAMPLE_BIT])
                        state_q <= ASC_ST_IDLE;
                ASC_ST_CONVERT:
                    if (conv_done)
                        state_q <= auto_q ? ASC_ST_SAMPLE : ASC_ST_IDLE;
                default:
                    state_q <= ASC_ST_IDLE;
            endcase
        end
    end

    // Sample bit mirrors sampling; writes ignored while converting.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sample_q <= 1'b0;
        else if (!enable_q)
            sample_q <= 1'b0;
        else if (conv_done)
            sample_q <= auto_q;
        else if (start_conv)
            sample_q <= 1'b0;
        else if (sw_low_wr && state_q != ASC_ST_CONVERT)
            sample_q <= pwdata[`ASC_LOW_SAMPLE_BIT];
    end

    // Done falls with the conversion start, rises with the buffer write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_q <= 1'b0;
        else if (conv_done)
            done_q <= 1'b1;
        else if (start_conv)
            done_q <= 1'b0;
    end

    // Sample time counter, restarted at every sampling start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sample_control_cnt_q <= 5'h00;
        else if (state_q != ASC_ST_SAMPLE)
            sample_control_cnt_q <= 5'h00;
        else if (tad_tick && sample_control_cnt_q != 5'h1F)
            sample_control_cnt_q <= sample_control_cnt_q + 5'h01;
    end

    // Conversion length counter; an abort discards the partial count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            conv_cnt_q <= 4'h0;
        else if (state_q != ASC_ST_CONVERT)
            conv_cnt_q <= 4'h0;
        else if (tad_tick)
            conv_cnt_q <= conv_cnt_q + 4'h1;
    end

    // Write pointer is also the channel index; disable keeps it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wr_ptr_q <= 4'h0;
        else if (conv_done)
            wr_ptr_q <= wr_ptr_q + 4'h1;
    end

    // Analog side handshakes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            conv_active_q <= 1'b0;
        else if (!enable_q || conv_done)
            conv_active_q <= 1'b0;
        else if (start_conv)
            conv_active_q <= 1'b1;
    end

    // ****************************************************************
    // Result buffer and outputs
    // ****************************************************************
    asc_result_buf u_buf (
        .pclk    (pclk),
        .hw_we   (conv_done),
        .hw_addr (wr_ptr_q),
        .hw_data (conv_data),
        .sw_we   (wr_en && is_buf(paddr)),
        .sw_addr (paddr[5:2]),
        .sw_data (pwdata[11:0]),
        .rd_addr (paddr[5:2]),
        .rd_data (buf_rd)
    );

    // Every output comes straight from a flip-flop
    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign analog_power = enable_q;
    assign sh_sample    = sample_q;
    assign conv_active  = conv_active_q;
    assign channel_sel  = wr_ptr_q;

endmodule

`default_nettype wire

// ==== hdl/asc_regs.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of the
 * A/D sample and convert sequencer.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ASC_OFF_CTRL_LOW     12'h000
`define ASC_OFF_CTRL_HIGH    12'h004
`define ASC_OFF_CTRL_THREE   12'h008
`define ASC_OFF_STATUS       12'h00C
`define ASC_OFF_BUF_BASE     12'h040
`define ASC_OFF_BUF_LAST     12'h07C

// ****************************************************************
// Field positions
// ****************************************************************
`define ASC_LOW_DONE_BIT     0
`define ASC_LOW_SAMPLE_BIT   1
`define ASC_LOW_AUTO_BIT     2
`define ASC_LOW_TRIG_LSB     4
`define ASC_HIGH_ENABLE_BIT  7
`define ASC_THREE_DIV_LSB    0
`define ASC_THREE_SAMPLE_TIME_COUNT_LSB   8
`define ASC_THREE_RC_BIT     15

// ****************************************************************
// Trigger codes, reset values and counts
// ****************************************************************
`define ASC_TRIG_SOFTWARE    4'h0
`define ASC_TRIG_CLOCKED     4'h7
`define ASC_RST_DIVIDER      8'h00
`define ASC_RST_SAMPLE_TIME_COUNT         5'h00
`define ASC_CONV_TAD         4'hC
`define ASC_BUF_DEPTH        16
`define ASC_DATA_W           12

`endif

// ==== hdl/asc_pkg.sv ====
/*
 * Types shared by the A/D sequencer modules.
 * Assumes asc_regs.svh is compiled alongside.
 */
package asc_pkg;

    // Sequencer phases; code 2'b11 is unused
    typedef enum logic [1:0] {
        ASC_ST_IDLE    = 2'b00,
        ASC_ST_SAMPLE  = 2'b01,
        ASC_ST_CONVERT = 2'b10
    } asc_state_t;

    typedef logic [3:0] asc_ptr_t;

endpackage

// ==== hdl/asc_tad_div.sv ====
/*
 * Conversion clock enable: one-cycle pulse per conversion clock period,
 * taken either from the prescaled bus clock or from the RC tick input.
 * Assumes pclk is the instruction clock (half the oscillator rate).
 */
`timescale 1ns/1ps
`default_nettype none

module asc_tad_div
    import asc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic       rc_select,
    input  wire logic       rc_tick,
    input  wire logic [7:0] divider,
    output logic            tad_tick
);

    logic [7:0] cnt_q;

    // Period = 2/Fosc * (divider + 1) = (divider + 1) pclk cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 8'h00;
        else if (!run || rc_select || cnt_q >= divider)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_q + 8'h01;
    end

    // RC source overrides the divider entirely
    always_comb
    begin
        if (!run)
            tad_tick = 1'b0;
        else if (rc_select)
            tad_tick = rc_tick;
        else
            tad_tick = (cnt_q >= divider);
    end

endmodule

`default_nettype wire

// ==== hdl/asc_result_buf.sv ====
/*
 * Result buffer words: one write port shared by the sequencer and software,
 * one asynchronous read port for the bus.
 * Contents are never cleared, not even by reset of the sequencer state.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"

module asc_result_buf
    import asc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        hw_we,
    input  wire asc_ptr_t    hw_addr,
    input  wire logic [11:0] hw_data,
    input  wire logic        sw_we,
    input  wire asc_ptr_t    sw_addr,
    input  wire logic [11:0] sw_data,
    input  wire asc_ptr_t    rd_addr,
    output logic [11:0]      rd_data
);

    logic [11:0] mem [`ASC_BUF_DEPTH];

    // Conversion write beats a same-cycle software write
    always_ff @(posedge pclk)
    begin
        if (hw_we)
            mem[hw_addr] <= hw_data;
        else if (sw_we)
            mem[sw_addr] <= sw_data;
    end

    assign rd_data = mem[rd_addr];

endmodule

`default_nettype wire

// ==== verification/asc_seq_props.sv ====
/*
 * Port checker for asc_sequencer: bus answer, phase order, conversion
 * length and buffer pointer stepping.
 * Assumes it is bound to asc_sequencer and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none

module asc_seq_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rc_tick,
    input wire logic        ext_trigger,
    input wire logic [11:0] conv_data,
    input wire logic        analog_power,
    input wire logic        sh_sample,
    input wire logic        conv_active,
    input wire logic [3:0]  channel_sel
);
    logic [9:0] cnt_q;

    // Cycles of the running conversion; a short count means the conversion ended early
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 10'h000;
        else if (conv_active)
            cnt_q <= cnt_q + 10'h001;
        else
            cnt_q <= 10'h000;
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    phase_excl_a: assert property (!(sh_sample && conv_active))
        else $error("sampling and converting together");
    off_idle_a: assert property (!analog_power |-> ##[0:1] !(sh_sample || conv_active))
        else $error("activity while disabled");
    sample_control_power_a: assert property ($rose(sh_sample) |-> analog_power)
        else $error("sampling while disabled");
    conv_start_a: assert property ($rose(conv_active) |-> $fell(sh_sample))
        else $error("conversion not at end of sampling");
    conv_len_a: assert property ($fell(conv_active) && analog_power |-> cnt_q >= 10'h00C)
        else $error("conversion too short");
    ptr_step_a: assert property ($fell(conv_active) && analog_power |-> channel_sel == $past(channel_sel) + 4'h1)
        else $error("pointer not stepped");
    chan_hold_a: assert property ($changed(channel_sel) |-> $fell(conv_active))
        else $error("pointer moved outside completion");

    cover property ($fell(conv_active) && analog_power);
    cover property (pslverr);
    cover property ($rose(sh_sample) && $past(conv_active));
endmodule

bind asc_sequencer asc_seq_chk chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rc_tick(rc_tick),
    .ext_trigger(ext_trigger), .conv_data(conv_data),
    .analog_power(analog_power), .sh_sample(sh_sample),
    .conv_active(conv_active), .channel_sel(channel_sel)
);

`default_nettype wire

// ==== verification/asc_core_model.sv ====
/*
 * Model of the sample-and-hold and converter core: RC tick and result data.
 * Assumes conv_active stays high for the whole conversion.
 */
`timescale 1ns/1ps
`default_nettype none

module asc_core_model #(
    parameter logic [11:0] BASE = 12'h5A0
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       analog_power,
    input  wire logic       conv_active,
    output logic            rc_tick,
    output var logic [11:0] conv_data
);
    logic [1:0]  rc_q;
    logic [11:0] cnt_q;
    logic        act_q;

    // RC oscillator, one tick in three cycles; stands still when unpowered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rc_q <= 2'h0;
        else if (!analog_power)
            rc_q <= 2'h0;
        else
            rc_q <= (rc_q == 2'h2) ? 2'h0 : rc_q + 2'h1;
    end
    assign rc_tick = (rc_q == 2'h2);

    // New result per conversion; lines toggle between conversions
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            act_q     <= 1'h0;
            cnt_q     <= 12'h000;
            conv_data <= 12'h000;
        end
        else
        begin
            act_q     <= conv_active;
            cnt_q     <= cnt_q + {11'h000, conv_active & !act_q};
            conv_data <= conv_active ? BASE + cnt_q : ~conv_data;
        end
    end
endmodule

`default_nettype wire

// ==== verification/testbench.sv ====
/*
 * Self-checking bench for asc_sequencer with a converter core model.
 * Assumes a one-access-cycle APB slave running on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"

module testbench;
    localparam logic [11:0] LO = `ASC_OFF_CTRL_LOW;
    localparam logic [11:0] HI = `ASC_OFF_CTRL_HIGH;
    localparam logic [11:0] TH = `ASC_OFF_CTRL_THREE;
    localparam logic [11:0] BF = `ASC_OFF_BUF_BASE;

    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, ext_trigger = 1'h0, act_m = 1'h0, e;
    logic        pready, pslverr, rc_tick, analog_power, sh_sample, conv_active;
    logic [11:0] paddr = 12'h000, conv_data;
    logic [31:0] pwdata = 32'h0000_0000, prdata, d;
    logic [3:0]  channel_sel;
    logic [11:0] exp_buf [16];
    int          num_errors = 0, total_checks = 0, wp = 0, tick_cnt = 0, n;

    asc_sequencer dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rc_tick(rc_tick),
        .ext_trigger(ext_trigger), .conv_data(conv_data),
        .analog_power(analog_power), .sh_sample(sh_sample),
        .conv_active(conv_active), .channel_sel(channel_sel)
    );
    asc_core_model model_u (
        .pclk(pclk), .presetn(presetn), .analog_power(analog_power),
        .conv_active(conv_active), .rc_tick(rc_tick), .conv_data(conv_data)
    );

    // 40 MHz clock
    initial forever #12.5 pclk = ~pclk;

    // Log each completed conversion; aborted ones leave no word
    always @(negedge pclk)
    begin
        if (act_m && !conv_active && analog_power)
        begin
            exp_buf[wp[3:0]] = conv_data;
            wp = wp + 1;
        end
        act_m = conv_active;
    end

    // Hang guard, far above the several hundred cycles the run needs
    always @(posedge pclk)
    begin
        tick_cnt <= tick_cnt + 1;
        if (tick_cnt == 20000)
        begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end

    task give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] x);
        total_checks = total_checks + 1;
        if (g !== x)
        begin
            num_errors = num_errors + 1;
            $display("BAD %0t got %h expected %h", $time, g, x);
        end
    endtask

    task nx(input int c);
        repeat (c) @(negedge pclk);
    endtask

    // One APB transfer; answer taken at the edge that samples pready high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && k < 16)
        begin
            k = k + 1;
            @(posedge pclk);
        end
        d = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(negedge pclk);
        chk(k < 16, 1'h1);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'h1, a, v);
    endtask

    task rd(input logic [11:0] a);
        apb(1'h0, a, 32'h0000_0000);
    endtask

    // Cycles of the next sampling (s=0) or conversion (s=1) phase
    task len(input logic s);
        int k;
        k = 0;
        n = 0;
        while ((s ? conv_active : sh_sample) !== 1'h1 && k < 400)
        begin
            k = k + 1;
            @(negedge pclk);
        end
        while ((s ? conv_active : sh_sample) === 1'h1 && n < 400)
        begin
            n = n + 1;
            @(negedge pclk);
        end
        chk(k < 400 && n < 400, 1'h1);
    endtask

    // Trigger changes only with the converter off, then settle
    task cfg(input logic [31:0] th, input logic [31:0] lo);
        wr(HI, 32'h0000_0000);
        wr(TH, th);
        wr(LO, lo);
        wr(HI, 32'h0000_0080);
        nx(8);
    endtask

    task t_reset();
        rd(LO);
        chk(d, 32'h0000_0000);
        rd(12'h010);
        chk({d[0], e}, 2'h1);
        chk(analog_power, 1'h0);
    endtask

    task t_manual();
        cfg(32'h0000_0000, 32'h0000_0000);
        chk(analog_power, 1'h1);
        wr(LO, 32'h0000_0002);
        nx(1);
        chk(sh_sample, 1'h1);
        rd(LO);
        chk(d[1:0], 2'h2);
        wr(LO, 32'h0000_0000);
        len(1'h1);
        chk(n, 12);
        nx(30);
        chk(sh_sample, 1'h0);
        rd(LO);
        chk(d[1:0], 2'h1);
        chk(channel_sel, wp[3:0]);
    endtask

    // Divider 1 gives two cycles per tick; three ticks of sampling
    task t_clocked();
        cfg(32'h0000_0301, 32'h0000_0070);
        wr(LO, 32'h0000_0072);
        len(1'h0);
        chk(n >= 4 && n <= 6, 1'h1);
        len(1'h1);
        chk(n, 24);
    endtask

    // RC ticks every third cycle; the large divider must not matter
    task t_rc();
        cfg(32'h0000_81FF, 32'h0000_0070);
        wr(LO, 32'h0000_0072);
        len(1'h0);
        len(1'h1);
        chk(n, 36);
    endtask

    task t_free();
        int w0;
        cfg(32'h0000_0100, 32'h0000_0074);
        wr(LO, 32'h0000_0076);
        w0 = wp;
        repeat (3)
        begin
            len(1'h1);
            chk(sh_sample, 1'h1);
        end
        nx(1);
        chk(wp - w0, 3);
        w0 = wp;
        wr(LO, 32'h0000_0070);
        len(1'h1);
        nx(20);
        chk(wp - w0, 1);
        chk(sh_sample | conv_active, 1'h0);
    endtask

    task t_soft_auto();
        cfg(32'h0000_0000, 32'h0000_0004);
        wr(LO, 32'h0000_0006);
        wr(LO, 32'h0000_0004);
        len(1'h1);
        chk(sh_sample, 1'h1);
        rd(LO);
        chk(d[2:1], 2'h3);
        wr(LO, 32'h0000_0000);
        len(1'h1);
        nx(20);
        chk(sh_sample, 1'h0);
    endtask

    task t_ext();
        cfg(32'h0000_0000, 32'h0000_0010);
        wr(LO, 32'h0000_0012);
        nx(6);
        chk(sh_sample & !conv_active, 1'h1);
        @(posedge pclk);
        ext_trigger <= 1'h1;
        @(posedge pclk);
        ext_trigger <= 1'h0;
        @(negedge pclk);
        len(1'h1);
        chk(n, 12);
    endtask

    // Long conversion cut by disable; buffer and settings must survive
    task t_abort();
        cfg(32'h0000_0305, 32'h0000_0000);
        wr(BF + 12'h03C, 32'h0000_0ABC);
        wr(LO, 32'h0000_0002);
        wr(LO, 32'h0000_0000);
        nx(10);
        chk(conv_active, 1'h1);
        wr(HI, 32'h0000_0000);
        nx(2);
        chk(sh_sample | conv_active, 1'h0);
        rd(TH);
        chk(d, 32'h0000_0305);
        wr(HI, 32'h0000_0080);
        rd(BF + 12'h03C);
        chk(d, 32'h0000_0ABC);
        chk(channel_sel, wp[3:0]);
    endtask

    task t_buffer();
        int i;
        for (i = 0; i < wp; i++)
        begin
            rd(BF + 12'(4 * i));
            chk(d, {20'h0_0000, exp_buf[i]});
        end
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        nx(1);
        t_reset();
        t_manual();
        t_clocked();
        t_rc();
        t_free();
        t_soft_auto();
        t_ext();
        t_abort();
        t_buffer();
        give_verdict();
    end
endmodule

`default_nettype wire
